/* hdl/btt_bank_timing.v */
// Bank timing trim registers and timestamp marker control behind Avalon-MM.
// Assumes fuse values valid at reset release and one 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "btt_map.vh"
// Behaviour
// - Marker enable puts timestamp on sample bit marker_lane.
// - Marker delayed same as analog sample latency.
// - Bank0 zero code in dual mode.
// - Bank0 quadrature code in single mode.
// - Bank1 zero code in dual mode.
// - Bank1 quadrature code in single mode.
// - Bank4 zero code in both modes.
// - Bank5 zero code in both modes.
// - Timing registers reset from fuse values.
// - Lane select clear: lane zero, enabled.
// - Lane select set: lane follows sample width.
module btt_bank_timing (
   // Clock and reset.
   input wire mclk,
   input wire rst_n,
   // Avalon-MM slave.
   input wire [11:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   // Fuse storage defaults.
   input wire [7:0] fuse_bank0_zero,
   input wire [7:0] fuse_bank0_quad,
   input wire [7:0] fuse_bank1_zero,
   input wire [7:0] fuse_bank1_quad,
   input wire [7:0] fuse_bank4_zero,
   input wire [7:0] fuse_bank5_zero,
   // Sample path.
   input wire timestamp_in,
   input wire [1:0] output_sample_width,
   input wire [11:0] sample_a_in,
   input wire [11:0] sample_b_in,
   output reg [11:0] sample_a_out,
   output reg [11:0] sample_b_out,
   output reg [5:0] lane_enable,
   // Applied timing codes.
   output wire [7:0] bank0_code,
   output wire [7:0] bank1_code,
   output wire [7:0] bank4_code,
   output wire [7:0] bank5_code,
   // Control levels.
   output wire sync_receiver_enable,
   output wire single_channel_mode
);
   reg [7:0] bank0_zero_phase_timing;
   reg [7:0] bank0_quadrature_timing;
   reg [7:0] bank1_zero_phase_timing;
   reg [7:0] bank1_quadrature_timing;
   reg [7:0] bank4_zero_phase_timing;
   reg [7:0] bank5_zero_phase_timing;
   reg [7:0] sample_marker_control;
   reg [7:0] lane_select_control;
   reg [7:0] mode_control;
   reg fuse_pending;
   reg ack;
   wire [9:0] idx;
   wire wr_en;
   wire marker_insert_enable;
   wire lane_sel;
   wire marker_late;
   wire [11:0] delayed_a;
   wire [11:0] delayed_b;
   reg [2:0] marker_lane;
   reg [11:0] lane_mask;

   // -------------------------------------------------------------------------
   // Bus decode.
   // -------------------------------------------------------------------------
   // One wait state per access; the answer comes on the second edge.
   assign idx = avs_address[11:2];
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr_en = avs_write & ack & avs_byteenable[0];

   function [7:0] btt_merge;
      input hit;
      input [7:0] old;
      input [7:0] val;
      begin
         btt_merge = hit ? val : old;
      end
   endfunction

   always @(posedge mclk) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read | avs_write) & ~ack;
      end
   end

   // -------------------------------------------------------------------------
   // Registers.
   // -------------------------------------------------------------------------
   always @(posedge mclk) begin
      if (!rst_n) begin
         fuse_pending <= 1'b1;
         bank0_zero_phase_timing <= 8'h00;
         bank0_quadrature_timing <= 8'h00;
         bank1_zero_phase_timing <= 8'h00;
         bank1_quadrature_timing <= 8'h00;
         bank4_zero_phase_timing <= 8'h00;
         bank5_zero_phase_timing <= 8'h00;
         sample_marker_control <= `BTT_RST_CTL;
         lane_select_control <= `BTT_RST_CTL;
         mode_control <= `BTT_RST_CTL;
      end else if (fuse_pending) begin
         fuse_pending <= 1'b0;
         bank0_zero_phase_timing <= fuse_bank0_zero;
         bank0_quadrature_timing <= fuse_bank0_quad;
         bank1_zero_phase_timing <= fuse_bank1_zero;
         bank1_quadrature_timing <= fuse_bank1_quad;
         bank4_zero_phase_timing <= fuse_bank4_zero;
         bank5_zero_phase_timing <= fuse_bank5_zero;
      end else if (wr_en) begin
         bank0_zero_phase_timing <= btt_merge(idx == `BTT_IDX_BANK0_ZERO,
            bank0_zero_phase_timing, avs_writedata[7:0]);
         bank0_quadrature_timing <= btt_merge(idx == `BTT_IDX_BANK0_QUAD,
            bank0_quadrature_timing, avs_writedata[7:0]);
         bank1_zero_phase_timing <= btt_merge(idx == `BTT_IDX_BANK1_ZERO,
            bank1_zero_phase_timing, avs_writedata[7:0]);
         bank1_quadrature_timing <= btt_merge(idx == `BTT_IDX_BANK1_QUAD,
            bank1_quadrature_timing, avs_writedata[7:0]);
         bank4_zero_phase_timing <= btt_merge(idx == `BTT_IDX_BANK4_ZERO,
            bank4_zero_phase_timing, avs_writedata[7:0]);
         bank5_zero_phase_timing <= btt_merge(idx == `BTT_IDX_BANK5_ZERO,
            bank5_zero_phase_timing, avs_writedata[7:0]);
         sample_marker_control <= btt_merge(idx == `BTT_IDX_MARKER_CTL,
            sample_marker_control, avs_writedata[7:0]);
         lane_select_control <= btt_merge(idx == `BTT_IDX_LANE_SEL,
            lane_select_control, avs_writedata[7:0]);
         mode_control <= btt_merge(idx == `BTT_IDX_MODE_CTL,
            mode_control, avs_writedata[7:0]);
      end
   end

   // -------------------------------------------------------------------------
   // Read data.
   // -------------------------------------------------------------------------
   always @(posedge mclk) begin
      if (!rst_n) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read & ~ack) begin
         case (idx)
            `BTT_IDX_BANK0_ZERO: avs_readdata <= {24'h000000, bank0_zero_phase_timing};
            `BTT_IDX_BANK0_QUAD: avs_readdata <= {24'h000000, bank0_quadrature_timing};
            `BTT_IDX_BANK1_ZERO: avs_readdata <= {24'h000000, bank1_zero_phase_timing};
            `BTT_IDX_BANK1_QUAD: avs_readdata <= {24'h000000, bank1_quadrature_timing};
            `BTT_IDX_BANK4_ZERO: avs_readdata <= {24'h000000, bank4_zero_phase_timing};
            `BTT_IDX_BANK5_ZERO: avs_readdata <= {24'h000000, bank5_zero_phase_timing};
            `BTT_IDX_MARKER_CTL: avs_readdata <= {24'h000000, sample_marker_control};
            `BTT_IDX_LANE_SEL: avs_readdata <= {24'h000000, lane_select_control};
            `BTT_IDX_MODE_CTL: avs_readdata <= {24'h000000, mode_control};
            `BTT_IDX_STATUS: avs_readdata <= {24'h000000, 5'h00, marker_lane};
            default: avs_readdata <= 32'h00000000;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Timing code selection.
   // -------------------------------------------------------------------------
   assign single_channel_mode = mode_control[`BTT_BIT_SINGLE_MODE];
   assign sync_receiver_enable = mode_control[`BTT_BIT_SYNC_RX_EN];
   // Converter A uses zero phase in dual mode and minus ninety in single mode.
   assign bank0_code = single_channel_mode ? bank0_quadrature_timing
                                           : bank0_zero_phase_timing;
   assign bank1_code = single_channel_mode ? bank1_quadrature_timing
                                           : bank1_zero_phase_timing;
   // Converter B stays at zero phase in both modes.
   assign bank4_code = bank4_zero_phase_timing;
   assign bank5_code = bank5_zero_phase_timing;

   // -------------------------------------------------------------------------
   // Timestamp marker path.
   // -------------------------------------------------------------------------
   assign marker_insert_enable = sample_marker_control[`BTT_BIT_MARKER_EN];
   assign lane_sel = lane_select_control[`BTT_BIT_LANE_SEL];

   // The marker and the samples pass through equal delay stages.
   btt_delay_line #(.DEPTH(`BTT_ANALOG_LATENCY)) u_marker_delay (
      .mclk(mclk),
      .rst_n(rst_n),
      .din(timestamp_in),
      .dout(marker_late)
   );

   genvar g;
   generate
      for (g = 0; g < 12; g = g + 1) begin : g_sample_delay
         btt_delay_line #(.DEPTH(`BTT_ANALOG_LATENCY)) u_a (
            .mclk(mclk),
            .rst_n(rst_n),
            .din(sample_a_in[g]),
            .dout(delayed_a[g])
         );
         btt_delay_line #(.DEPTH(`BTT_ANALOG_LATENCY)) u_b (
            .mclk(mclk),
            .rst_n(rst_n),
            .din(sample_b_in[g]),
            .dout(delayed_b[g])
         );
      end
   endgenerate

   always @* begin
      marker_lane = `BTT_LANE_W12;
      if (lane_sel) begin
         case (output_sample_width)
            `BTT_WIDTH_10: marker_lane = `BTT_LANE_W10;
            `BTT_WIDTH_8: marker_lane = `BTT_LANE_W8;
            default: marker_lane = `BTT_LANE_W12;
         endcase
      end
      lane_mask = 12'h001 << marker_lane;
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         sample_a_out <= 12'h000;
         sample_b_out <= 12'h000;
         lane_enable <= 6'h00;
      end else begin
         if (marker_insert_enable) begin
            sample_a_out <= (delayed_a & ~lane_mask) | (lane_mask & {12{marker_late}});
            sample_b_out <= (delayed_b & ~lane_mask) | (lane_mask & {12{marker_late}});
         end else begin
            sample_a_out <= delayed_a;
            sample_b_out <= delayed_b;
         end
         // Lane zero stays enabled in lane-select-clear mode whatever the width.
         lane_enable <= {3'h0, output_sample_width == `BTT_WIDTH_12, 1'b0, 1'b1}
                        | ((marker_insert_enable & lane_sel) ? lane_mask[5:0] : 6'h00);
      end
   end
endmodule // btt_bank_timing
`default_nettype wire

/* hdl/btt_delay_line.v */
// Fixed-length shift delay that matches the marker to the sample path latency.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module btt_delay_line #(
   parameter DEPTH = 4
) (
   // Clock and reset.
   input wire mclk,
   input wire rst_n,
   // Data.
   input wire din,
   output wire dout
);
   reg [DEPTH-1:0] pipe;

   always @(posedge mclk) begin
      if (!rst_n) begin
         pipe <= {DEPTH{1'b0}};
      end else begin
         pipe <= {pipe[DEPTH-2:0], din};
      end
   end

   assign dout = pipe[DEPTH-1];
endmodule // btt_delay_line
`default_nettype wire

/* hdl/btt_map.vh */
// Register map constants for the bank timing trim and timestamp control block.
// Assumes inclusion by bare name from design files under hdl/.
`ifndef BTT_MAP_VH
`define BTT_MAP_VH
// ----------------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------------
`define BTT_IDX_BANK0_ZERO 10'h102
`define BTT_IDX_BANK0_QUAD 10'h103
`define BTT_IDX_BANK1_ZERO 10'h112
`define BTT_IDX_BANK1_QUAD 10'h113
`define BTT_IDX_BANK4_ZERO 10'h142
`define BTT_IDX_BANK5_ZERO 10'h152
`define BTT_IDX_MARKER_CTL 10'h160
`define BTT_IDX_LANE_SEL 10'h161
`define BTT_IDX_MODE_CTL 10'h170
`define BTT_IDX_STATUS 10'h171
// ----------------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------------
`define BTT_BIT_MARKER_EN 0
`define BTT_BIT_LANE_SEL 0
`define BTT_BIT_SINGLE_MODE 0
`define BTT_BIT_SYNC_RX_EN 1
`define BTT_RST_CTL 8'h00
`define BTT_WIDTH_12 2'h0
`define BTT_WIDTH_10 2'h1
`define BTT_WIDTH_8 2'h2
`define BTT_LANE_W12 3'h0
`define BTT_LANE_W10 3'h2
`define BTT_LANE_W8 3'h4
// ----------------------------------------------------------------------------
// Timing counts.
// ----------------------------------------------------------------------------
`define BTT_ANALOG_LATENCY 4
`define BTT_FUSE_LOAD_CYCLES 2'h1
`endif

/* sim/btt_bank_timing_chk.sv */
// Checker for the bank timing trim block: bus answer, sample path, marker and holds.
// Assumes binding to btt_bank_timing with one clock and a synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module btt_bank_timing_chk (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Register bus.
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   // Sample path.
   input wire logic timestamp_in,
   input wire logic [11:0] sample_a_in,
   input wire logic [11:0] sample_b_in,
   input wire logic [11:0] sample_a_out,
   input wire logic [11:0] sample_b_out,
   input wire logic [5:0] lane_enable,
   // Control outputs.
   input wire logic [7:0] bank4_code,
   input wire logic sync_receiver_enable
);
   // ----------------------------------------------------------------------
   // Cycles since reset release, saturating at seven.
   // ----------------------------------------------------------------------
   logic [2:0] up;
   always @(posedge mclk) begin
      if (!rst_n) up <= 3'h0;
      else if (up != 3'h7) up <= up + 3'h1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_held;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_done;
      (avs_read || avs_write) && !avs_waitrequest;
   endsequence
   property p_mark(int k);
      up == 3'h7 && sample_a_out[k] != $past(sample_a_in[k], 5) |->
         sample_a_out[k] == $past(timestamp_in, 5) && sample_b_out[k] == $past(timestamp_in, 5);
   endproperty
   chk_one_wait: assert property (s_held |=> s_done) else $error("bus wait not one cycle");
   chk_idle_low: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait high while idle");
   chk_read_upper: assert property (s_done |-> avs_readdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   chk_lane_zero: assert property (up >= 3'h2 |-> lane_enable[0])
      else $error("lane zero disabled");
   chk_path_latency: assert property (up == 3'h7 |->
      {sample_a_out[11:5], sample_a_out[3], sample_a_out[1], sample_b_out[11:5],
       sample_b_out[3], sample_b_out[1]} == $past({sample_a_in[11:5], sample_a_in[3],
       sample_a_in[1], sample_b_in[11:5], sample_b_in[3], sample_b_in[1]}, 5))
      else $error("sample latency wrong");
   chk_mark_lane0: assert property (p_mark(0)) else $error("lane 0 marker wrong");
   chk_mark_lane2: assert property (p_mark(2)) else $error("lane 2 marker wrong");
   chk_mark_lane4: assert property (p_mark(4)) else $error("lane 4 marker wrong");
   chk_bank4_hold: assert property (up >= 3'h2 && !$past(avs_write) |-> $stable(bank4_code))
      else $error("bank 4 code moved");
   chk_sync_hold: assert property (up >= 3'h2 && $changed(sync_receiver_enable) |->
      $past(avs_write)) else $error("sync enable moved");
endmodule // btt_bank_timing_chk
bind btt_bank_timing btt_bank_timing_chk btt_bank_timing_chk_i (.mclk, .rst_n, .avs_read,
   .avs_write, .avs_waitrequest, .avs_readdata, .timestamp_in, .sample_a_in, .sample_b_in,
   .sample_a_out, .sample_b_out, .lane_enable, .bank4_code, .sync_receiver_enable);
`default_nettype wire

/* sim/btt_bank_timing_test.sv */
// Self-checking bench for the bank timing trim block.
// Assumes the design files and the map header on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "btt_map.vh"
module btt_bank_timing_test;
   logic mclk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, timestamp_in = 1'b0;
   logic [11:0] avs_address = 12'h0, sample_a_in = 12'h0, sample_b_in = 12'h0, a, b;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [3:0] avs_byteenable = 4'hf, lane = 4'h0;
   logic [1:0] output_sample_width = 2'h0, wd = 2'h0;
   logic [7:0] fz [6], rv [6], bank0_code, bank1_code, bank4_code, bank5_code;
   logic [9:0] ix [6];
   logic avs_waitrequest, sync_receiver_enable, single_channel_mode, t, en = 1'b0;
   logic [11:0] sample_a_out, sample_b_out;
   logic [5:0] lane_enable;
   logic [2:0] quiet = 3'h7;
   logic [24:0] sq [$], e;
   logic [31:0] rq [$];
   int fail_count = 0, total_checks = 0, n, i;
   btt_bank_timing btt_bank_timing_i (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .fuse_bank0_zero(fz[0]), .fuse_bank0_quad(fz[1]), .fuse_bank1_zero(fz[2]),
      .fuse_bank1_quad(fz[3]), .fuse_bank4_zero(fz[4]), .fuse_bank5_zero(fz[5]),
      .timestamp_in, .output_sample_width, .sample_a_in, .sample_b_in, .sample_a_out,
      .sample_b_out, .lane_enable, .bank0_code, .bank1_code, .bank4_code, .bank5_code,
      .sync_receiver_enable, .single_channel_mode);
   // ----------------------------------------------------------------------
   // Clock, checking tasks and bus master.
   // ----------------------------------------------------------------------
   initial forever #25 mclk = ~mclk;
   task report_and_stop;
      if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [3:0] be,
      input logic [7:0] exp);
      @(posedge mclk);
      avs_address <= {idx, 2'h0};
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      output_sample_width <= wd;
      avs_read <= !w;
      avs_write <= w;
      if (!w) rq.push_back({24'h0, exp});
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         fail_count++;
         report_and_stop;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // ----------------------------------------------------------------------
   // Sample stream with expected marker, and the two result monitors.
   // ----------------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst_n) begin
         a = 12'($urandom);
         b = 12'($urandom);
         t = 1'($urandom);
         sample_a_in <= a;
         sample_b_in <= b;
         timestamp_in <= t;
         if (en) begin
            a[lane] = t;
            b[lane] = t;
         end
         if (avs_write) foreach (sq[k]) sq[k][24] = 1'b0;
         sq.push_back({quiet == 3'h0 && !avs_write, a, b});
         if (avs_write) quiet <= 3'h7;
         else if (quiet != 3'h0) quiet <= quiet - 3'h1;
      end
   end
   always @(negedge mclk) begin
      if (sq.size() > 5) begin
         e = sq.pop_front();
         if (e[24]) cmp({8'h0, sample_a_out, sample_b_out}, {8'h0, e[23:0]});
      end
   end
   always @(posedge mclk) begin
      if (avs_read && !avs_waitrequest && rq.size() > 0) cmp(avs_readdata, rq.pop_front());
   end
   // ----------------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------------
   initial begin
      n = $urandom(45);
      ix = '{`BTT_IDX_BANK0_ZERO, `BTT_IDX_BANK0_QUAD, `BTT_IDX_BANK1_ZERO,
         `BTT_IDX_BANK1_QUAD, `BTT_IDX_BANK4_ZERO, `BTT_IDX_BANK5_ZERO};
      foreach (fz[k]) begin
         fz[k] = 8'($urandom);
         rv[k] = fz[k];
      end
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      foreach (ix[k]) bus(1'b0, ix[k], 8'h0, 4'hf, rv[k]);
      bus(1'b0, `BTT_IDX_MARKER_CTL, 8'h0, 4'hf, `BTT_RST_CTL);
      bus(1'b0, 10'h3ff, 8'h0, 4'hf, 8'h00);
      foreach (ix[k]) begin
         rv[k] = 8'($urandom);
         bus(1'b1, ix[k], rv[k], 4'hf, 8'h0);
         bus(1'b1, ix[k], ~rv[k], 4'he, 8'h0);
         bus(1'b0, ix[k], 8'h0, 4'hf, rv[k]);
      end
      for (i = 0; i < 2; i++) begin
         bus(1'b1, `BTT_IDX_MODE_CTL, {6'h0, 1'b1, i[0]}, 4'hf, 8'h0);
         repeat (2) @(posedge mclk);
         cmp(32'(bank0_code), 32'(rv[i]));
         cmp(32'(bank1_code), 32'(rv[2 + i]));
         cmp(32'(bank4_code), 32'(rv[4]));
         cmp(32'(bank5_code), 32'(rv[5]));
         cmp({30'h0, single_channel_mode, sync_receiver_enable}, {30'h0, i[0], 1'b1});
      end
      bus(1'b1, `BTT_IDX_MARKER_CTL, 8'h01, 4'hf, 8'h0);
      en = 1'b1;
      for (i = 0; i < 6; i++) begin
         wd = 2'(i % 3);
         bus(1'b1, `BTT_IDX_LANE_SEL, 8'(i / 3), 4'hf, 8'h0);
         lane = (i < 3) ? 4'h0 : 4'(2 * (i % 3));
         repeat (20) @(posedge mclk);
         cmp({31'h0, lane_enable[0]}, 32'h1);
         cmp({31'h0, lane_enable[lane]}, 32'h1);
         bus(1'b0, `BTT_IDX_STATUS, 8'h0, 4'hf, 8'(lane));
      end
      bus(1'b1, `BTT_IDX_MARKER_CTL, 8'h00, 4'hf, 8'h0);
      en = 1'b0;
      repeat (20) @(posedge mclk);
      report_and_stop;
   end
endmodule // btt_bank_timing_test
`default_nettype wire
